// ==== cmg_ctrl.sv ====
`timescale 1ns/100ps
`include "cmg_consts.svh"
module cmg_ctrl (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // serial control pins
  input wire logic serial_clock_pin,
  input wire logic serial_data_pin,
  input wire logic frame_latch_pin_i,
  output logic frame_latch_pin_o,
  output logic frame_latch_pin_oe,
  // mode pin
  input wire logic mode_pin_i,
  output logic mode_pin_o,
  output logic mode_pin_oe,
  output logic mode_pullup_en,
  // internal sources
  input wire logic system_clock,
  input wire cmg_pkg::cmg_flags_t status_flags,
  // results
  output logic three_wire_mode,
  output cmg_pkg::cmg_wr_t reg_write,
  output logic [15:0] pin_ctrl_q,
  output logic [15:0] if_cfg_q
);
  logic [1:0] sclk_s_q, sda_s_q, fl_s_q, mode_s_q, system_clock_s_q;
  logic sclk_prev_q, fl_prev_q, system_clock_prev_q;
  logic [23:0] shift_q, shift_d;
  logic [5:0] cnt_q, cnt_d;
  logic [7:0] next_addr_q, next_addr_d;
  logic burst_q, burst_d;
  logic [15:0] pin_ctrl_d, if_cfg_d;
  cmg_pkg::cmg_wr_t wr_d;
  cmg_pkg::cmg_pu_t pu_q, pu_d;
  logic [1:0] div_cnt_q, div_cnt_d;
  logic div_clk_q, div_clk_d;
  logic gp_q, gp_d;
  logic sclk_rise, fl_rise, sys_edge, mode_io, sel_three, gp_val;
  // every pin input passes two flops before use
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sclk_s_q <= 2'h0;
      sda_s_q <= 2'h0;
      fl_s_q <= 2'h3;
      mode_s_q <= 2'h3;
      system_clock_s_q <= 2'h0;
      sclk_prev_q <= 1'b0;
      fl_prev_q <= 1'b1;
      system_clock_prev_q <= 1'b0;
    end else begin
      sclk_s_q <= {sclk_s_q[0], serial_clock_pin};
      sda_s_q <= {sda_s_q[0], serial_data_pin};
      fl_s_q <= {fl_s_q[0], frame_latch_pin_i};
      mode_s_q <= {mode_s_q[0], mode_pin_i};
      system_clock_s_q <= {system_clock_s_q[0], system_clock};
      sclk_prev_q <= sclk_s_q[1];
      fl_prev_q <= fl_s_q[1];
      system_clock_prev_q <= system_clock_s_q[1];
    end
  end
  assign mode_io = pin_ctrl_q[`CMG_MODEIO_BIT];
  // override engaged once pull-up sequencer leaves the on state
  assign sel_three = (pu_q != cmg_pkg::CMG_PU_ON) | mode_s_q[1];
  assign three_wire_mode = sel_three;
  assign sclk_rise = sclk_s_q[1] & ~sclk_prev_q;
  assign fl_rise = fl_s_q[1] & ~fl_prev_q;
  assign sys_edge = system_clock_s_q[1] ^ system_clock_prev_q;
  // serial shifter and register writes
  always_comb begin
    shift_d = shift_q;
    cnt_d = cnt_q;
    next_addr_d = next_addr_q;
    burst_d = burst_q;
    pin_ctrl_d = pin_ctrl_q;
    if_cfg_d = if_cfg_q;
    wr_d = '0;
    if (sel_three && !fl_s_q[1] && sclk_rise) begin
      shift_d = {shift_q[22:0], sda_s_q[1]};
      cnt_d = cnt_q + 6'h01;
      // address byte is complete once the 24th bit arrives
      if (cnt_q == 6'(`CMG_WORD_BITS - 1))
        next_addr_d = shift_q[22:15];
      // each further 16 bits is one more word; folding the count back avoids a length limit
      if (cnt_q == 6'(`CMG_WORD_BITS + `CMG_DATA_BITS - 1)) begin
        cnt_d = 6'(`CMG_WORD_BITS);
        burst_d = 1'b1;
        next_addr_d = next_addr_q + 8'h01;
      end
    end
    if (sel_three && fl_rise) begin
      if (cnt_q >= 6'(`CMG_WORD_BITS)) begin
        wr_d.valid = 1'b1;
        wr_d.addr = (burst_q && if_cfg_q[`CMG_ADDRESS_AUTO_INCREMENT_BIT]) ?
          next_addr_q : shift_q[23:`CMG_ADDR_LSB];
        wr_d.data = shift_q[15:0];
      end
      cnt_d = 6'h0;
      burst_d = 1'b0;
    end
    if (wr_d.valid && wr_d.addr == `CMG_ADDR_PIN_CTRL) begin
      // the mode-as-io bit may only be set while running 3-wire
      pin_ctrl_d = wr_d.data;
    end
    if (wr_d.valid && wr_d.addr == `CMG_ADDR_IF_CFG)
      if_cfg_d = wr_d.data;
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      shift_q <= 24'h0;
      cnt_q <= 6'h0;
      next_addr_q <= 8'h0;
      burst_q <= 1'b0;
      pin_ctrl_q <= `CMG_PIN_CTRL_RST;
      if_cfg_q <= `CMG_IF_CFG_RST;
      reg_write <= '0;
    end else begin
      shift_q <= shift_d;
      cnt_q <= cnt_d;
      next_addr_q <= next_addr_d;
      burst_q <= burst_d;
      pin_ctrl_q <= pin_ctrl_d;
      if_cfg_q <= if_cfg_d;
      reg_write <= wr_d;
    end
  end
  // pull-up sequencer: override first, pull-up off one cycle later
  always_comb begin
    case (pu_q)
      cmg_pkg::CMG_PU_ON: pu_d = mode_io ? cmg_pkg::CMG_PU_OVR : cmg_pkg::CMG_PU_ON;
      cmg_pkg::CMG_PU_OVR: pu_d = mode_io ? cmg_pkg::CMG_PU_OFF : cmg_pkg::CMG_PU_ON;
      cmg_pkg::CMG_PU_OFF: pu_d = mode_io ? cmg_pkg::CMG_PU_OFF : cmg_pkg::CMG_PU_OVR;
      default: pu_d = cmg_pkg::CMG_PU_ON;
    endcase
  end
  // divider counts both edges so code n gives an output period of n+1 input periods
  always_comb begin
    div_cnt_d = div_cnt_q;
    div_clk_d = div_clk_q;
    if (sys_edge) begin
      if (div_cnt_q >= pin_ctrl_q[`CMG_DIV_MSB:`CMG_DIV_LSB]) begin
        div_cnt_d = 2'h0;
        div_clk_d = ~div_clk_q;
      end else begin
        div_cnt_d = div_cnt_q + 2'h1;
      end
    end
    case (cmg_pkg::cmg_fn_t'(pin_ctrl_q[`CMG_SEL_MSB:`CMG_SEL_LSB]))
      cmg_pkg::CMG_FN_JACK: gp_val = status_flags.jack;
      cmg_pkg::CMG_FN_TEMP: gp_val = status_flags.temp_ok;
      cmg_pkg::CMG_FN_MUTE: gp_val = status_flags.mute;
      cmg_pkg::CMG_FN_CLK: gp_val = div_clk_q;
      cmg_pkg::CMG_FN_LOCK: gp_val = status_flags.pll_lock;
      default: gp_val = 1'b0;
    endcase
    gp_d = gp_val ^ pin_ctrl_q[`CMG_POL_BIT];
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pu_q <= cmg_pkg::CMG_PU_ON;
      div_cnt_q <= 2'h0;
      div_clk_q <= 1'b0;
      gp_q <= 1'b0;
    end else begin
      pu_q <= pu_d;
      div_cnt_q <= div_cnt_d;
      div_clk_q <= div_clk_d;
      gp_q <= gp_d;
    end
  end
  // output functions; select 000 keeps the pin an input
  assign frame_latch_pin_o = gp_q;
  assign frame_latch_pin_oe = !sel_three &&
    (pin_ctrl_q[`CMG_SEL_MSB:`CMG_SEL_LSB] != 3'h0);
  assign mode_pin_o = gp_q;
  assign mode_pin_oe = (pu_q != cmg_pkg::CMG_PU_ON) &&
    (pin_ctrl_q[`CMG_SEL_MSB:`CMG_SEL_LSB] != 3'h0);
  assign mode_pullup_en = (pu_q != cmg_pkg::CMG_PU_OFF);

  // pull-up stays on one cycle after the override, then drops
  sequence pullup_drop_s;
    mode_pullup_en ##1 !mode_pullup_en;
  endsequence

  pullup_order_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !mode_pullup_en |-> three_wire_mode) else $error("pull-up off without override");
  pullup_delay_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(mode_io) |=> pullup_drop_s) else $error("pull-up sequencing wrong");
  mode_force_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    mode_io |-> ##[1:2] three_wire_mode) else $error("override missing");
  mode_low_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (pu_q == cmg_pkg::CMG_PU_ON && !mode_s_q[1]) |-> !three_wire_mode)
    else $error("low mode not two-wire");
  latch_write_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (sel_three && fl_rise && cnt_q == 6'h18) |=> reg_write.valid &&
    reg_write.data == $past(shift_q[15:0])) else $error("latch lost word");
  no_write_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !fl_rise |=> !reg_write.valid) else $error("spurious write");
  pin_store_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_write.valid && reg_write.addr == `CMG_ADDR_PIN_CTRL |-> pin_ctrl_q == reg_write.data)
    else $error("pin control not stored");
  shift_in_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (sel_three && !fl_s_q[1] && sclk_rise) |=> shift_q[0] == $past(sda_s_q[1]))
    else $error("bit not shifted");
  cs_free_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    three_wire_mode |-> !frame_latch_pin_oe) else $error("latch pin driven");
  reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (pin_ctrl_q[`CMG_SEL_MSB:`CMG_SEL_MSB - 1] == 2'h3) |=>
    gp_q == $past(pin_ctrl_q[`CMG_POL_BIT])) else $error("reserved select not idle");
endmodule // cmg_ctrl

// ==== cmg_consts.svh ====
`ifndef CMG_CONSTS_SVH
`define CMG_CONSTS_SVH
`define CMG_ADDR_PIN_CTRL 8'h08
`define CMG_ADDR_IF_CFG 8'h09
`define CMG_SEL_LSB 0
`define CMG_SEL_MSB 2
`define CMG_POL_BIT 3
`define CMG_DIV_LSB 4
`define CMG_DIV_MSB 5
`define CMG_MODEIO_BIT 7
`define CMG_ADDRESS_AUTO_INCREMENT_BIT 1
`define CMG_PIN_CTRL_RST 16'h0000
`define CMG_IF_CFG_RST 16'h0002
`define CMG_WORD_BITS 24
`define CMG_DATA_BITS 16
`define CMG_ADDR_LSB 16
`endif

// ==== cmg_pkg.sv ====
package cmg_pkg;
  typedef enum logic [2:0] {
    CMG_FN_LATCH = 3'h0,
    CMG_FN_JACK = 3'h1,
    CMG_FN_TEMP = 3'h2,
    CMG_FN_MUTE = 3'h3,
    CMG_FN_CLK = 3'h4,
    CMG_FN_LOCK = 3'h5
  } cmg_fn_t;
  typedef enum logic [1:0] {
    CMG_PU_ON = 2'b00,
    CMG_PU_OVR = 2'b01,
    CMG_PU_OFF = 2'b11
  } cmg_pu_t;
  typedef struct packed {
    logic jack;
    logic temp_ok;
    logic mute;
    logic pll_lock;
  } cmg_flags_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] data;
    logic valid;
  } cmg_wr_t;
endpackage

// ==== cmg_host_model.sv ====
`timescale 1ns/100ps
module cmg_host_model (
  // clock
  input wire logic clk_sys,
  // serial control pins
  output logic sclk,
  output logic sdat,
  output logic latch
);
  initial begin
    sclk = 1'b0;
    sdat = 1'b0;
    latch = 1'b1;
  end
  // msb first; halves of 4 cycles stay clear of the 3 cycle minimum
  task automatic send(input int n, input logic [47:0] w);
    @(negedge clk_sys);
    latch = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdat = w[i];
      repeat (4) @(negedge clk_sys);
      sclk = 1'b1;
      repeat (4) @(negedge clk_sys);
      sclk = 1'b0;
    end
    latch = 1'b1;
    // released data line must not keep showing the last bit
    sdat = ~sdat;
    repeat (12) @(negedge clk_sys);
  endtask
endmodule // cmg_host_model

// ==== control_mode_and_gpio_select_tb.sv ====
`timescale 1ns/100ps
module control_mode_and_gpio_select_tb;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic src_clk = 1'b0;
  logic mode_hiz = 1'b1;
  logic mode_lvl = 1'b1;
  cmg_pkg::cmg_flags_t flags = 4'hB;
  cmg_pkg::cmg_wr_t rw;
  cmg_pkg::cmg_wr_t last_wr;
  logic sclk, sdat, latch, fl_o, fl_oe, md_o, md_oe, pu_en, three_w;
  logic [15:0] pin_ctrl, if_cfg;
  logic [2:0] sels [5] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
  logic [4:0] expb = 5'h0D;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;
  wire fl_pin = fl_oe ? fl_o : latch;
  wire md_pin = md_oe ? md_o : (mode_hiz ? pu_en : mode_lvl);
  cmg_host_model host (.clk_sys(clk_sys), .sclk(sclk), .sdat(sdat), .latch(latch));
  cmg_ctrl dut (.clk_sys(clk_sys), .rst_b(rst_b), .serial_clock_pin(sclk),
    .serial_data_pin(sdat), .frame_latch_pin_i(fl_pin), .frame_latch_pin_o(fl_o),
    .frame_latch_pin_oe(fl_oe), .mode_pin_i(md_pin), .mode_pin_o(md_o),
    .mode_pin_oe(md_oe), .mode_pullup_en(pu_en), .system_clock(src_clk),
    .status_flags(flags), .three_wire_mode(three_w), .reg_write(rw),
    .pin_ctrl_q(pin_ctrl), .if_cfg_q(if_cfg));
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  // source clock locked to clk_sys so divided periods are exact
  initial begin
    forever begin
      repeat (8) @(negedge clk_sys);
      src_clk = ~src_clk;
    end
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (rw.valid === 1'b1) last_wr <= rw;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host.send(24, {24'h0, a, d});
  endtask
  task automatic two_wire(input logic on);
    mode_hiz = ~on;
    mode_lvl = ~on;
    repeat (8) @(negedge clk_sys);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (3) @(negedge clk_sys);
    check(pin_ctrl, 16'h0000, "pin ctrl reset");
    check(if_cfg, 16'h0002, "if cfg reset");
    check(three_w, 16'h1, "floating mode pin");
    check(pu_en, 16'h1, "pull-up at reset");
    $display("test reset done");
    wr(8'h08, 16'h0015);
    check(last_wr.addr, 16'h0008, "write address");
    check(pin_ctrl, 16'h0015, "latched word");
    host.send(20, 48'h0_8003);
    check(pin_ctrl, 16'h0015, "short frame");
    host.send(40, {8'h0, 8'h08, 16'h0011, 16'h0003});
    check(last_wr.addr, 16'h0009, "incremented address");
    check(last_wr.data, 16'h0003, "incremented data");
    check(if_cfg, 16'h0003, "incremented register");
    wr(8'h09, 16'h0000);
    check(if_cfg, 16'h0000, "auto-inc off");
    host.send(40, {8'h0, 16'h1234, 8'h08, 16'h0004});
    check(pin_ctrl, 16'h0004, "no increment");
    wr(8'h09, 16'h0002);
    $display("test frames done");
    // mode-as-io is left clear whenever two_wire drives the mode pin low
    // slow clock enable lives outside this block and is taken as set for jack detect
    for (int i = 0; i < 10; i++) begin
      wr(8'h08, {12'h0, i[0], sels[i / 2]});
      two_wire(1'b1);
      check(three_w, 16'h0, "low mode pin");
      check(fl_oe, 16'h1, "latch pin driven");
      check(fl_pin, 16'(expb[i / 2] ^ i[0]), "pin function");
      two_wire(1'b0);
    end
    $display("test functions done");
    for (int c = 0; c < 4; c++) begin
      wr(8'h08, {10'h0, c[1:0], 4'h4});
      two_wire(1'b1);
      @(posedge fl_pin);
      n = cyc;
      @(posedge fl_pin);
      check(16'(cyc - n), 16'(16 * (c + 1)), "divided period");
      two_wire(1'b0);
    end
    $display("test divider done");
    wr(8'h08, 16'h0080);
    check(pu_en, 16'h0, "pull-up off");
    mode_hiz = 1'b0;
    mode_lvl = 1'b0;
    repeat (8) @(negedge clk_sys);
    check(three_w, 16'h1, "forced 3-wire");
    wr(8'h08, 16'h008A);
    check(md_oe, 16'h1, "mode driver on");
    check(md_pin, 16'h1, "mode pin output");
    mode_hiz = 1'b1;
    wr(8'h08, 16'h0000);
    check(pu_en, 16'h1, "pull-up back");
    $display("test mode pin done");
    report_and_stop();
  end
endmodule // control_mode_and_gpio_select_tb
